// ===== hw/swf_pkg.sv
// swf_pkg: register map, field positions and reset values of the
// selective-wake frame filter. Assumes an 8-bit internal register port.
package swf_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_EXT_ID_HIGH_BYTE = 8'h30;
   localparam logic [7:0] ADDR_EXT_ID_MID_BYTE = 8'h31;
   localparam logic [7:0] ADDR_ID_LOW_AND_FORMAT = 8'h32;
   localparam logic [7:0] ADDR_BASE_ID_LOW = 8'h33;
   localparam logic [7:0] ADDR_EXT_MASK_TOP = 8'h34;
   localparam logic [7:0] ADDR_EXT_MASK_MID = 8'h35;
   localparam logic [7:0] ADDR_EXT_MASK_LOW = 8'h36;
   localparam logic [7:0] ADDR_BASE_MASK_HIGH = 8'h37;
   localparam logic [7:0] ADDR_BASE_MASK_LOW_LENGTH_MATCH = 8'h38;
   localparam logic [7:0] ADDR_MATCH_BYTE_FIRST = 8'h39;
   localparam logic [7:0] ADDR_MATCH_BYTE_LAST = 8'h40;
   localparam logic [7:0] ADDR_WAKE_RESERVED_FIRST = 8'h41;
   localparam logic [7:0] ADDR_WAKE_RESERVED_LAST = 8'h43;
   localparam logic [7:0] ADDR_WAKE_RATE_CONFIG = 8'h44;
   localparam logic [7:0] ADDR_FRAME_ERROR_COUNT = 8'h45;
   localparam logic [7:0] ADDR_ERROR_OVERFLOW_THRESHOLD = 8'h46;
   localparam logic [7:0] ADDR_WAKE_SETUP_STATUS = 8'h47;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int FORMAT_BIT = 5;
   localparam int DATA_COMPARE_BIT = 0;
   localparam int LENGTH_LSB = 1;
   localparam int FD_IGNORED_BIT = 7;
   localparam int RATE_LSB = 4;
   localparam int RATIO_LSB = 2;
   localparam int SETUP_COMPLETE_BIT = 7;
   localparam int MATCH_BYTES = 8;

   // ----------------------------------------------------------------
   // reset values and writable-bit masks
   // ----------------------------------------------------------------
   localparam logic [7:0] RESET_ZERO = 8'h00;
   localparam logic [7:0] RESET_WAKE_RATE_CONFIG = 8'h50;
   localparam logic [7:0] RESET_ERROR_OVERFLOW_THRESHOLD = 8'h1f;
   localparam logic [7:0] WMASK_BASE_ID_LOW = 8'hfc;
   localparam logic [7:0] WMASK_EXT_MASK_TOP = 8'h03;
   localparam logic [7:0] WMASK_WAKE_RATE_CONFIG = 8'hfc;

   // ----------------------------------------------------------------
   // arbitration rate codes
   // ----------------------------------------------------------------
   localparam logic [2:0] RATE_50K = 3'h0;
   localparam logic [2:0] RATE_100K = 3'h1;
   localparam logic [2:0] RATE_125K = 3'h2;
   localparam logic [2:0] RATE_250K = 3'h3;
   localparam logic [2:0] RATE_500K = 3'h5;
   localparam logic [2:0] RATE_1M = 3'h7;
   localparam logic [1:0] RATIO_UP_TO_4X = 2'h0;
   localparam logic [1:0] RATIO_5X_TO_10X = 2'h1;

endpackage

// ===== hw/swf_frame_filter.sv
// swf_frame_filter: selective-wake id/data match registers, rate setup,
// and the frame error counter with its overflow flag.
// Assumes a protocol decoder in front that reports each finished frame as a
// one-cycle strobe with its decoded fields, synchronous to clk_sys.
//
// Notes on behaviour
// - format bit picks 11-bit or 29-bit id
// - extended id bits 17:0 in three registers
// - base id split over third, fourth register
// - extended mask bits 17:0 in three registers
// - base mask in fourth and length register
// - compare off: length, data, remote accepted
// - compare on: length equal, data any-one, no remote
// - eight match bytes from offset 39h up
// - rate code table, reset 500 kbps
// - fd ratio codes 00b and 01b
// - fd frames count as error unless ignored
// - counter up on stuff or crc errors
// - counter down on good frame if nonzero
// - increment past threshold overflows, sets flag
// - counter cleared on detect enable, silence
// - three reserved registers read zero
// - threshold resets to 31
// - config writes clear setup complete bit
`timescale 1ns/1ps

module swf_frame_filter
   import swf_pkg::*;
#(
   parameter int ID_BITS = 29,
   parameter int COUNT_BITS = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // register port
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   // decoded frame from the bus side
   input wire logic frameDone,
   input wire logic frameError,
   input wire logic frameFd,
   input wire logic frameRemote,
   input wire logic frameExtended,
   input wire logic [ID_BITS-1:0] frameId,
   input wire logic [3:0] frameLength,
   input wire logic [63:0] frameData,
   // device context
   input wire logic frameDetectEnable,
   input wire logic silenceDetected,
   input wire logic overflowClear,
   // results
   output logic wakeMatch,
   output logic errorOverflowFlag,
   output logic wakeSetupComplete,
   output logic fdFramesIgnored,
   output logic [2:0] arbitrationRateCode,
   output logic [1:0] fdRatioCode,
   output logic rateCodeReserved
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // any write in this range invalidates the wake setup
   function automatic logic isWakeConfigAddr(input logic [7:0] a);
      isWakeConfigAddr = ((a >= ADDR_EXT_ID_HIGH_BYTE) && (a <= ADDR_WAKE_RATE_CONFIG))
         || (a == ADDR_ERROR_OVERFLOW_THRESHOLD);
   endfunction

   // storage registers
   logic [7:0] extIdHighByte;
   logic [7:0] extIdMidByte;
   logic [7:0] idLowAndFormat;
   logic [7:0] baseIdLow;
   logic [7:0] extMaskTop;
   logic [7:0] extMaskMid;
   logic [7:0] extMaskLow;
   logic [7:0] baseMaskHigh;
   logic [7:0] baseMaskLowLengthMatch;
   logic [7:0] matchDataByte [MATCH_BYTES];
   logic [7:0] wakeRateConfig;
   logic [7:0] errorOverflowThreshold;
   logic [COUNT_BITS-1:0] frameErrorCount;
   logic detectEnableSeen;

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         extIdHighByte <= RESET_ZERO;
         extIdMidByte <= RESET_ZERO;
         idLowAndFormat <= RESET_ZERO;
         baseIdLow <= RESET_ZERO;
      end else if (regWrite) begin
         if (regAddr == ADDR_EXT_ID_HIGH_BYTE) begin
            extIdHighByte <= regWrData;
         end else if (regAddr == ADDR_EXT_ID_MID_BYTE) begin
            extIdMidByte <= regWrData;
         end else if (regAddr == ADDR_ID_LOW_AND_FORMAT) begin
            idLowAndFormat <= regWrData;
         end else if (regAddr == ADDR_BASE_ID_LOW) begin
            baseIdLow <= regWrData & WMASK_BASE_ID_LOW;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         extMaskTop <= RESET_ZERO;
         extMaskMid <= RESET_ZERO;
         extMaskLow <= RESET_ZERO;
         baseMaskHigh <= RESET_ZERO;
         baseMaskLowLengthMatch <= RESET_ZERO;
      end else if (regWrite) begin
         if (regAddr == ADDR_EXT_MASK_TOP) begin
            extMaskTop <= regWrData & WMASK_EXT_MASK_TOP;
         end else if (regAddr == ADDR_EXT_MASK_MID) begin
            extMaskMid <= regWrData;
         end else if (regAddr == ADDR_EXT_MASK_LOW) begin
            extMaskLow <= regWrData;
         end else if (regAddr == ADDR_BASE_MASK_HIGH) begin
            baseMaskHigh <= regWrData;
         end else if (regAddr == ADDR_BASE_MASK_LOW_LENGTH_MATCH) begin
            baseMaskLowLengthMatch <= regWrData;
         end
      end
   end

   generate
      for (genvar b = 0; b < MATCH_BYTES; b++) begin : gMatchByte
         always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               matchDataByte[b] <= RESET_ZERO;
            end else if (regWrite && (regAddr == ADDR_MATCH_BYTE_FIRST + 8'(b))) begin
               matchDataByte[b] <= regWrData;
            end
         end
      end
   endgenerate

   // rate setup and threshold with their reset values
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wakeRateConfig <= RESET_WAKE_RATE_CONFIG;
         errorOverflowThreshold <= RESET_ERROR_OVERFLOW_THRESHOLD;
      end else if (regWrite) begin
         if (regAddr == ADDR_WAKE_RATE_CONFIG) begin
            wakeRateConfig <= regWrData & WMASK_WAKE_RATE_CONFIG;
         end else if (regAddr == ADDR_ERROR_OVERFLOW_THRESHOLD) begin
            errorOverflowThreshold <= regWrData;
         end
      end
   end

   // setup complete: set by software, dropped by any config write
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wakeSetupComplete <= 1'b0;
      end else if (regWrite) begin
         if (regAddr == ADDR_WAKE_SETUP_STATUS) begin
            wakeSetupComplete <= regWrData[SETUP_COMPLETE_BIT];
         end else if (isWakeConfigAddr(regAddr)) begin
            wakeSetupComplete <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration outputs
   // ----------------------------------------------------------------

   // rate fields decoded for the bit timing logic
   assign arbitrationRateCode = wakeRateConfig[RATE_LSB +: 3];
   assign fdRatioCode = wakeRateConfig[RATIO_LSB +: 2];
   assign fdFramesIgnored = wakeRateConfig[FD_IGNORED_BIT];

   // reserved codes are flagged so the decoder can refuse to arm
   always_comb begin
      case (arbitrationRateCode)
         RATE_50K, RATE_100K, RATE_125K, RATE_250K, RATE_500K, RATE_1M: rateCodeReserved = 1'b0;
         default: rateCodeReserved = 1'b1;
      endcase
      if ((fdRatioCode != RATIO_UP_TO_4X) && (fdRatioCode != RATIO_5X_TO_10X)) begin
         rateCodeReserved = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // identifier match
   // ----------------------------------------------------------------
   logic [ID_BITS-1:0] wantId;
   logic [ID_BITS-1:0] careMask;
   logic idMatch;

   always_comb begin
      wantId = '0;
      careMask = '0;
      if (idLowAndFormat[FORMAT_BIT]) begin
         wantId = {idLowAndFormat[4:0], baseIdLow[7:2], extIdHighByte, extIdMidByte, idLowAndFormat[7:6]};
         careMask = ~{baseMaskHigh, baseMaskLowLengthMatch[7:5], extMaskTop[1:0], extMaskMid, extMaskLow};
      end else begin
         wantId[10:0] = {idLowAndFormat[4:0], baseIdLow[7:2]};
         careMask[10:0] = ~{baseMaskHigh, baseMaskLowLengthMatch[7:5]};
      end
   end

   // masked bits are don't care; format must agree
   assign idMatch = (frameExtended == idLowAndFormat[FORMAT_BIT])
      && (((frameId ^ wantId) & careMask) == '0);

   // ----------------------------------------------------------------
   // length and data match
   // ----------------------------------------------------------------
   logic [3:0] byteCount;
   logic [MATCH_BYTES-1:0] byteHit;
   logic dataMatch;

   // lengths above eight still only cover the eight match bytes
   assign byteCount = (frameLength > 4'h8) ? 4'h8 : frameLength;

   generate
      for (genvar b = 0; b < MATCH_BYTES; b++) begin : gByteHit
         assign byteHit[b] = (4'(b) < byteCount) && ((frameData[8*b +: 8] & matchDataByte[b]) != 8'h00);
      end
   endgenerate

   always_comb begin
      if (!baseMaskLowLengthMatch[DATA_COMPARE_BIT]) begin
         // compare off: length and data assumed valid
         dataMatch = 1'b1;
      end else begin
         // compare on: remote refused, length equal, any one bit
         dataMatch = !frameRemote && (frameLength == baseMaskLowLengthMatch[LENGTH_LSB +: 4]) && (|byteHit);
      end
   end

   // wake only on clean frames, with setup confirmed and detection on
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wakeMatch <= 1'b0;
      end else begin
         wakeMatch <= frameDone && !frameError && !frameFd && wakeSetupComplete && frameDetectEnable
            && idMatch && dataMatch;
      end
   end

   // ----------------------------------------------------------------
   // frame error counter
   // ----------------------------------------------------------------
   logic countUp;
   logic countDown;
   logic countClear;
   logic overflowEvent;

   // error frames; fd frames count unless ignored
   assign countUp = frameDone && (frameError || (frameFd && !fdFramesIgnored));
   // good classic frames count down, never below zero
   assign countDown = frameDone && !frameError && !frameFd && (frameErrorCount != '0);
   // enabling detection or bus silence empties the counter
   assign countClear = (frameDetectEnable && !detectEnableSeen) || silenceDetected;
   assign overflowEvent = countUp && !countClear && (frameErrorCount == errorOverflowThreshold);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         detectEnableSeen <= 1'b0;
      end else begin
         detectEnableSeen <= frameDetectEnable;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         frameErrorCount <= '0;
      end else if (countClear) begin
         frameErrorCount <= '0;
      end else if (overflowEvent) begin
         frameErrorCount <= '0;
      end else if (countUp) begin
         frameErrorCount <= frameErrorCount + COUNT_BITS'(1);
      end else if (countDown) begin
         frameErrorCount <= frameErrorCount - COUNT_BITS'(1);
      end
   end

   // sticky flag; a new overflow wins over a clear in the same cycle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         errorOverflowFlag <= 1'b0;
      end else if (overflowEvent) begin
         errorOverflowFlag <= 1'b1;
      end else if (overflowClear) begin
         errorOverflowFlag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   logic [7:0] next_regRdData;

   always_comb begin
      next_regRdData = 8'h00;
      if (regAddr == ADDR_EXT_ID_HIGH_BYTE) begin
         next_regRdData = extIdHighByte;
      end else if (regAddr == ADDR_EXT_ID_MID_BYTE) begin
         next_regRdData = extIdMidByte;
      end else if (regAddr == ADDR_ID_LOW_AND_FORMAT) begin
         next_regRdData = idLowAndFormat;
      end else if (regAddr == ADDR_BASE_ID_LOW) begin
         next_regRdData = baseIdLow;
      end else if (regAddr == ADDR_EXT_MASK_TOP) begin
         next_regRdData = extMaskTop;
      end else if (regAddr == ADDR_EXT_MASK_MID) begin
         next_regRdData = extMaskMid;
      end else if (regAddr == ADDR_EXT_MASK_LOW) begin
         next_regRdData = extMaskLow;
      end else if (regAddr == ADDR_BASE_MASK_HIGH) begin
         next_regRdData = baseMaskHigh;
      end else if (regAddr == ADDR_BASE_MASK_LOW_LENGTH_MATCH) begin
         next_regRdData = baseMaskLowLengthMatch;
      end else if ((regAddr >= ADDR_MATCH_BYTE_FIRST) && (regAddr <= ADDR_MATCH_BYTE_LAST)) begin
         next_regRdData = matchDataByte[3'(regAddr - ADDR_MATCH_BYTE_FIRST)];
      end else if ((regAddr >= ADDR_WAKE_RESERVED_FIRST) && (regAddr <= ADDR_WAKE_RESERVED_LAST)) begin
         next_regRdData = 8'h00;
      end else if (regAddr == ADDR_WAKE_RATE_CONFIG) begin
         next_regRdData = wakeRateConfig;
      end else if (regAddr == ADDR_FRAME_ERROR_COUNT) begin
         next_regRdData = 8'(frameErrorCount);
      end else if (regAddr == ADDR_ERROR_OVERFLOW_THRESHOLD) begin
         next_regRdData = errorOverflowThreshold;
      end else if (regAddr == ADDR_WAKE_SETUP_STATUS) begin
         next_regRdData = {wakeSetupComplete, 7'h00};
      end
   end

   // read data is held until the next read
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         regRdData <= 8'h00;
      end else if (regRead) begin
         regRdData <= next_regRdData;
      end
   end

endmodule // swf_frame_filter

// ===== verif/swf_frame_filter_chk.sv
// checker: port-level properties of the selective-wake frame filter
// assumes one clock domain, bound to every swf_frame_filter instance
`timescale 1ns/1ps
module swf_frame_filter_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // register port
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   // frame and context
   input wire logic frameDone,
   input wire logic frameError,
   input wire logic frameFd,
   input wire logic frameDetectEnable,
   input wire logic overflowClear,
   // results
   input wire logic wakeMatch,
   input wire logic errorOverflowFlag,
   input wire logic wakeSetupComplete,
   input wire logic fdFramesIgnored,
   input wire logic [2:0] arbitrationRateCode,
   input wire logic [1:0] fdRatioCode,
   input wire logic rateCodeReserved
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // ------------------------------------------------------------
   // register side
   // ------------------------------------------------------------
   a_rate_write: assert property (
      regWrite && regAddr == 8'h44 |=> arbitrationRateCode == $past(regWrData[6:4]))
      else $error("rate code not taken from write");
   a_ratio_fd_write: assert property (
      regWrite && regAddr == 8'h44 |=> {fdFramesIgnored, fdRatioCode} == $past({regWrData[7], regWrData[3:2]}))
      else $error("ratio or fd bit not taken from write");
   a_code_reserved: assert property (
      rateCodeReserved == (arbitrationRateCode inside {3'h4, 3'h6} || fdRatioCode[1]))
      else $error("reserved code flag wrong");
   a_setup_cleared: assert property (
      regWrite && (regAddr inside {[8'h30:8'h44], 8'h46}) |=> !wakeSetupComplete)
      else $error("setup complete survived a config write");
   a_reserved_read: assert property (
      regRead && (regAddr inside {[8'h41:8'h43]}) |=> regRdData == 8'h00)
      else $error("reserved place read nonzero");
   // ------------------------------------------------------------
   // overflow and wake
   // ------------------------------------------------------------
   a_ovf_cause: assert property (
      $rose(errorOverflowFlag) |-> $past(frameDone && (frameError || frameFd)))
      else $error("overflow rose without an error frame");
   a_ovf_sticky: assert property (
      errorOverflowFlag && !overflowClear |=> errorOverflowFlag)
      else $error("overflow flag dropped by itself");
   a_ovf_clear: assert property (
      overflowClear && !frameDone |=> !errorOverflowFlag)
      else $error("overflow flag not cleared");
   a_wake_gate: assert property (
      wakeMatch |-> $past(frameDone && !frameError && !frameFd && frameDetectEnable && wakeSetupComplete))
      else $error("wake without a clean frame");
   c_wake: cover property (wakeMatch);
   c_overflow: cover property ($rose(errorOverflowFlag));
   c_setup: cover property ($rose(wakeSetupComplete));
endmodule // swf_frame_filter_chk

bind swf_frame_filter swf_frame_filter_chk swf_frame_filter_chk_inst (.clk_sys(clk_sys), .nrst(nrst),
   .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
   .frameDone(frameDone), .frameError(frameError), .frameFd(frameFd), .frameDetectEnable(frameDetectEnable),
   .overflowClear(overflowClear), .wakeMatch(wakeMatch), .errorOverflowFlag(errorOverflowFlag),
   .wakeSetupComplete(wakeSetupComplete), .fdFramesIgnored(fdFramesIgnored),
   .arbitrationRateCode(arbitrationRateCode), .fdRatioCode(fdRatioCode), .rateCodeReserved(rateCodeReserved));

// ===== verif/swf_can_node.sv
// partner: another bus node, reporting each finished frame as a decoded strobe
// assumes clk_sys from the bench; one frame per call of send
`timescale 1ns/1ps
module swf_can_node (
   // clock
   input wire logic clk_sys,
   // decoded frame
   output logic frameDone = 1'b0,
   output logic frameError = 1'b0,
   output logic frameFd = 1'b0,
   output logic frameRemote = 1'b0,
   output logic frameExtended = 1'b0,
   output logic [28:0] frameId = 29'h0,
   output logic [3:0] frameLength = 4'h0,
   output logic [63:0] frameData = 64'h0
);
   // fields hold for one edge only, then invert so a stale sample never passes
   task automatic send(input logic e, f, r, x, input logic [28:0] id, input logic [3:0] ln, input logic [63:0] d);
      @(posedge clk_sys);
      frameDone <= 1'b1;
      {frameError, frameFd, frameRemote, frameExtended, frameId, frameLength, frameData} <= {e, f, r, x, id, ln, d};
      @(posedge clk_sys);
      frameDone <= 1'b0;
      {frameError, frameFd, frameRemote, frameExtended, frameId, frameLength, frameData} <= ~{e, f, r, x, id, ln, d};
   endtask
endmodule // swf_can_node

// ===== verif/swf_frame_filter_bench.sv
// bench: register map, rate codes, wake matching and error counter against a model
// assumes the filter, its checker and the partner node; one 200 MHz clock
`timescale 1ns/1ps
module swf_frame_filter_bench;
   import swf_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regAddr = 8'h0;
   logic [7:0] regWrData = 8'h0;
   logic frameDetectEnable = 1'b1;
   logic silenceDetected = 1'b0;
   logic overflowClear = 1'b0;
   logic [7:0] regRdData;
   logic frameDone, frameError, frameFd, frameRemote, frameExtended;
   logic [28:0] frameId;
   logic [3:0] frameLength;
   logic [63:0] frameData;
   logic wakeMatch, errorOverflowFlag, wakeSetupComplete, fdFramesIgnored, rateCodeReserved;
   logic [2:0] arbitrationRateCode;
   logic [1:0] fdRatioCode;
   // model state
   logic [7:0] mr [48:71];
   int cnt = 0;
   bit flag = 0;
   bit setup = 0;
   int miscompares = 0;
   int checkCount = 0;
   logic e, f, r, x, sd, oc, hit, expW;
   logic [3:0] ln;
   logic [63:0] d;
   logic [28:0] t, m, id;

   swf_frame_filter #(.ID_BITS(29), .COUNT_BITS(8)) swf_frame_filter_inst (.clk_sys(clk_sys), .nrst(nrst),
      .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .frameDone(frameDone), .frameError(frameError), .frameFd(frameFd), .frameRemote(frameRemote),
      .frameExtended(frameExtended), .frameId(frameId), .frameLength(frameLength), .frameData(frameData),
      .frameDetectEnable(frameDetectEnable), .silenceDetected(silenceDetected), .overflowClear(overflowClear),
      .wakeMatch(wakeMatch), .errorOverflowFlag(errorOverflowFlag), .wakeSetupComplete(wakeSetupComplete),
      .fdFramesIgnored(fdFramesIgnored), .arbitrationRateCode(arbitrationRateCode), .fdRatioCode(fdRatioCode),
      .rateCodeReserved(rateCodeReserved));
   swf_can_node swf_can_node_inst (.clk_sys(clk_sys), .frameDone(frameDone), .frameError(frameError),
      .frameFd(frameFd), .frameRemote(frameRemote), .frameExtended(frameExtended), .frameId(frameId),
      .frameLength(frameLength), .frameData(frameData));

   always #2.5 clk_sys = ~clk_sys;

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
      checkCount++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic completeRun();
      $display("checks %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // write, then mirror it in the model; config writes drop setup-complete
   task automatic wr(input int a, input logic [7:0] v);
      @(posedge clk_sys);
      regWrite <= 1'b1;
      regAddr <= 8'(a);
      regWrData <= v;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      if ((a >= 48 && a <= 68) || a == 70) setup = 0;
      if (a == 71) setup = v[7];
      else if (a >= 48 && a <= 70) mr[a] = v;
      #1 chk("setup", wakeSetupComplete, setup);
   endtask
   // expected read value: read-only bits and reserved places read zero
   function automatic logic [7:0] rexp(input int a);
      if (a == 69) return 8'(cnt);
      if (a == 71) return {setup, 7'h0};
      if (a < 48 || a > 71 || (a inside {[65:67]})) return 8'h00;
      if (a == 51 || a == 68) return mr[a] & 8'hfc;
      if (a == 52) return mr[a] & 8'h03;
      return mr[a];
   endfunction
   task automatic rd(input int a);
      @(posedge clk_sys);
      regRead <= 1'b1;
      regAddr <= 8'(a);
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1 chk("read", regRdData, rexp(a));
   endtask

   // hang guard
   initial begin
      repeat (100000) @(posedge clk_sys);
      miscompares++;
      completeRun();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      foreach (mr[i]) mr[i] = 8'h00;
      mr[68] = 8'h50;
      mr[70] = 8'h1f;
      void'($urandom(32'h2fe35114));
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      // reset values, then random writes and readback over the map and its edges
      for (int a = 46; a <= 73; a++) rd(a);
      for (int a = 46; a <= 73; a++) wr(a, 8'($urandom));
      for (int a = 46; a <= 73; a++) rd(a);
      // every rate and ratio code, with the read-only low bits written as ones
      for (int c = 0; c < 32; c++) begin
         wr(68, {c[0], c[4:0], 2'b11});
         chk("rate", arbitrationRateCode, c[4:2]);
         chk("ratio", fdRatioCode, c[1:0]);
         chk("fdignore", fdFramesIgnored, c[0]);
         chk("rsvdcode", rateCodeReserved, (c[4:2] == 4 || c[4:2] == 6 || c[1]));
         rd(68);
      end
      // random frames against the matching and counting model
      for (int i = 0; i < 300; i++) begin
         if (i % 30 == 0) begin
            for (int a = 48; a <= 64; a++) wr(a, (a >= 52 && a <= 55) ? 8'($urandom & $urandom & $urandom) : 8'($urandom));
            wr(68, 8'($urandom));
            wr(70, 8'($urandom % 4 + 1));
            wr(71, {1'($urandom % 4 != 0), 7'h0});
            @(posedge clk_sys);
            frameDetectEnable <= 1'b0;
            @(posedge clk_sys);
            frameDetectEnable <= 1'b1;
            cnt = 0;
            rd(69);
         end
         sd = ($urandom % 8 == 0);
         oc = ($urandom % 5 == 0);
         if (sd || oc) begin
            @(posedge clk_sys);
            silenceDetected <= sd;
            overflowClear <= oc;
            @(posedge clk_sys);
            silenceDetected <= 1'b0;
            overflowClear <= 1'b0;
            if (sd) cnt = 0;
            if (oc) flag = 0;
         end
         x = 1'($urandom);
         t = {mr[50][4:0], mr[51][7:2], mr[48], mr[49], mr[50][7:6]};
         m = {mr[55], mr[56][7:5], mr[52][1:0], mr[53], mr[54]};
         if (!x) begin
            t = t >> 18;
            m = m >> 18;
         end
         id = ($urandom % 2) ? t : t ^ (29'h1 << ($urandom % (x ? 29 : 11)));
         f = ($urandom % 5 == 0);
         e = !f && ($urandom % 3 == 0);
         r = ($urandom % 4 == 0);
         ln = ($urandom % 2) ? mr[56][4:1] : 4'($urandom);
         d = {$urandom, $urandom} & {$urandom, $urandom};
         hit = 0;
         for (int k = 0; k < 8 && k < ln; k++) hit |= |(d[8*k +: 8] & mr[57 + k]);
         expW = !e && !f && setup && mr[50][5] == x && ((t ^ id) & ~m) == 0
            && (!mr[56][0] || (!r && ln == mr[56][4:1] && hit));
         if (e || (f && !mr[68][7])) begin
            if (cnt == mr[70]) begin
               cnt = 0;
               flag = 1;
            end else
               cnt++;
         end else if (!f && cnt > 0)
            cnt--;
         swf_can_node_inst.send(e, f, r, x, id, ln, d);
         #1 chk("wake", wakeMatch, expW);
         chk("overflow", errorOverflowFlag, flag);
         rd(69);
      end
      completeRun();
   end
endmodule // swf_frame_filter_bench
